// File: logic/cs_wait_pkg.sv
// Shared constants for the chip-select and wait-state unit.
// Assumes a 20-bit memory address, a 16-bit I/O address and 16-bit registers.
package cs_wait_pkg;
    // Register offsets in I/O space
    localparam logic [15:0] OFS_UPPER_CTL = 16'hffa0;
    localparam logic [15:0] OFS_LOWER_CTL = 16'hffa2;
    localparam logic [15:0] OFS_PER_BASE = 16'hffa4;
    localparam logic [15:0] OFS_MID_CTL = 16'hffa6;
    localparam logic [15:0] OFS_PER_OPT = 16'hffa8;
    // Reset values equal the start-up defaults
    localparam logic [15:0] RST_UPPER_CTL = 16'h80bf;
    localparam logic [15:0] RST_LOWER_CTL = 16'h7fbf;
    localparam logic [15:0] RST_PER_BASE = 16'h007f;
    localparam logic [15:0] RST_MID_CTL = 16'h81ff;
    localparam logic [15:0] RST_PER_OPT = 16'ha0bf;
    localparam logic [15:0] READ_NONE = 16'h0000;
    // Field positions
    localparam int WAIT2_LSB = 0;
    localparam int WAIT2_MSB = 1;
    localparam int CODE3_MSB = 2;
    localparam int NORDY_BIT = 2;
    localparam int PER_NORDY_BIT = 3;
    localparam int PSRAM_BIT = 6;
    localparam int HIGH_SEL_BIT = 7;
    localparam int MID_SIZE_LSB = 8;
    localparam int MID_SIZE_MSB = 14;
    localparam int REGION_LSB = 12;
    localparam int REGION_MSB = 15;
    localparam int PER_BASE_LSB = 10;
    localparam int PER_BASE_MSB = 15;
    localparam int MID_UNIT_BITS = 13;
    // Strobe layout
    localparam int LOW_PER_N = 4;
    localparam int HIGH_PER_N = 2;
    localparam int HIGH_PER_FIRST = 5;
    localparam int STROBE_N = 3 + LOW_PER_N + HIGH_PER_N;
    localparam int SEL_UPPER = 0;
    localparam int SEL_LOWER = 1;
    localparam int SEL_MID = 2;
    localparam int SEL_LOW_PER = 3;
    localparam int SEL_HIGH_PER = SEL_LOW_PER + LOW_PER_N;
    // Timing: enable base time and per-wait stretch
    localparam int CLK_NS = 50;
    localparam int ENABLE_BASE_NS = 100;
    localparam int WAIT_STEP_NS = 25;
    localparam int BASE_CYCLES = (ENABLE_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_CYCLES = (WAIT_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] BASE_LAST = 2'(BASE_CYCLES - 1);
    localparam logic [3:0] WAIT_ZERO = 4'h0;
    localparam logic [2:0] CODE_SLOWEST = 3'h7;

    // Cycle sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BASE = 2'b01,
        ST_WAIT = 2'b10,
        ST_READY = 2'b11
    } cycle_state_t;

    // Peripheral delay code to wait-state count
    function automatic logic [3:0] waitFromCode(input logic [2:0] code);
        case (code)
            3'h4: waitFromCode = 4'h5;
            3'h5: waitFromCode = 4'h7;
            3'h6: waitFromCode = 4'h9;
            3'h7: waitFromCode = 4'hf;
            default: waitFromCode = {1'b0, code};
        endcase
    endfunction
endpackage

// File: logic/wait_counter.sv
// Down counter that stretches a bus cycle by wait states.
// Assumes load and decrement are never asked in the same cycle.
`timescale 1ns/1ns
module wait_counter
    import cs_wait_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [3:0] loadValue,
    input wire logic step,
    output logic isZero
);
    logic [3:0] count_reg; // Wait states still to run

    // Load at cycle start, then count down to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= WAIT_ZERO;
        end else if (load) begin
            count_reg <= loadValue;
        end else if (step && count_reg != WAIT_ZERO) begin
            count_reg <= count_reg - 4'(STEP_CYCLES);
        end
    end

    assign isZero = (count_reg == WAIT_ZERO);
endmodule

// File: logic/region_decoder.sv
// Combinational address decoder for memory and peripheral select regions.
// Assumes the address is stable in the cycle the bus cycle starts.
`timescale 1ns/1ns
module region_decoder
    import cs_wait_pkg::*;
(
    input wire logic [19:0] addr,
    input wire logic ioCycle,
    input wire logic [15:0] upperCtl,
    input wire logic [15:0] lowerCtl,
    input wire logic [15:0] perBase,
    input wire logic [15:0] midCtl,
    input wire logic [15:0] perOpt,
    output logic [STROBE_N-1:0] sel,
    output logic [3:0] waitCount,
    output logic useReady
);
    logic [STROBE_N-1:0] hit; // Raw region hits before priority
    logic [19:0] midBase; // Mid window start
    logic [20:0] midOffset; // Distance above the mid base
    logic [20:0] midSize; // Mid window length in bytes

    assign midBase = {midCtl[REGION_MSB:REGION_LSB], 16'h0000};
    assign midOffset = {1'b0, addr} - {1'b0, midBase};
    assign midSize = {1'b0, perOpt[MID_SIZE_MSB:MID_SIZE_LSB], 13'h0000};

    // Memory regions: upper runs from its base to the top of memory
    always_comb begin
        hit = '0;
        hit[SEL_UPPER] = !ioCycle
            && addr[19:16] >= upperCtl[REGION_MSB:REGION_LSB];
        hit[SEL_LOWER] = !ioCycle
            && addr[19:16] <= lowerCtl[REGION_MSB:REGION_LSB];
        hit[SEL_MID] = !ioCycle && addr >= midBase && !midOffset[20]
            && midOffset < midSize;
    end

    // One 256-byte I/O block per peripheral select, stacked upward
    genvar gi;
    generate
        for (gi = 0; gi < LOW_PER_N + HIGH_PER_N; gi++) begin : g_per
            localparam int BLOCK = (gi < LOW_PER_N) ? gi : gi - LOW_PER_N + HIGH_PER_FIRST;
            localparam logic [7:0] BLOCK_OFS = 8'(BLOCK);
            logic enabled;
            assign enabled = (gi < LOW_PER_N) || perOpt[HIGH_SEL_BIT];
            assign sel[SEL_LOW_PER+gi] = enabled && ioCycle
                && addr[15:8] == ({perBase[PER_BASE_MSB:PER_BASE_LSB], 2'b00}
                + BLOCK_OFS);
        end
    endgenerate

    // Mid window wins over upper where they overlap, so only one fires
    // Continuous assigns keep every bit of sel under one kind of driver
    assign sel[SEL_MID] = hit[SEL_MID];
    assign sel[SEL_UPPER] = hit[SEL_UPPER] && !hit[SEL_MID];
    assign sel[SEL_LOWER] = hit[SEL_LOWER] && !hit[SEL_MID] && !hit[SEL_UPPER];

    // Wait count and ready use of the chosen region
    always_comb begin
        waitCount = WAIT_ZERO;
        useReady = 1'b0;
        if (sel[SEL_UPPER]) begin
            waitCount = {2'b00, upperCtl[WAIT2_MSB:WAIT2_LSB]};
            useReady = !upperCtl[NORDY_BIT];
        end else if (sel[SEL_MID]) begin
            waitCount = {2'b00, midCtl[WAIT2_MSB:WAIT2_LSB]};
            useReady = !midCtl[NORDY_BIT];
        end else if (sel[SEL_LOWER]) begin
            waitCount = {2'b00, lowerCtl[WAIT2_MSB:WAIT2_LSB]};
            useReady = !lowerCtl[NORDY_BIT];
        end else if (|sel[SEL_HIGH_PER+:HIGH_PER_N]) begin
            waitCount = {2'b00, perOpt[WAIT2_MSB:WAIT2_LSB]};
            useReady = !perOpt[NORDY_BIT];
        end else if (|sel[SEL_LOW_PER+:LOW_PER_N]) begin
            waitCount = waitFromCode(perBase[CODE3_MSB:WAIT2_LSB]);
            useReady = !perBase[PER_NORDY_BIT];
        end
    end
endmodule

// File: logic/chip_select_wait_state_unit.sv
// Chip-select and wait-state unit: control registers, cycle sequencer, strobes.
// Assumes one bus cycle at a time, started by a one-cycle cycleStart pulse
// with address and direction valid in that same cycle.
`timescale 1ns/1ns
module chip_select_wait_state_unit
    import cs_wait_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cycleStart,
    input wire logic [19:0] addr,
    input wire logic ioCycle,
    input wire logic writeCycle,
    input wire logic [15:0] writeData,
    input wire logic extReady,
    output logic [15:0] readData,
    output logic regHit,
    output logic cycleBusy,
    output logic cycleDone,
    output logic upperStrobe_n,
    output logic lowerStrobe_n,
    output logic firstMidStrobe_n,
    output logic [LOW_PER_N-1:0] lowPeriphStrobes_n,
    output logic [HIGH_PER_N-1:0] highPeriphStrobes_n
);
    // Control registers
    logic [15:0] upperCtl_reg;
    logic [15:0] lowerCtl_reg;
    logic [15:0] perBase_reg;
    logic [15:0] midCtl_reg;
    logic [15:0] perOpt_reg;
    logic [15:0] readData_reg; // Read answer, held until the next read
    logic regHit_reg; // Last cycle hit a control register

    // Sequencer state
    cycle_state_t state_reg;
    cycle_state_t state_next;
    logic [1:0] baseCnt_reg; // Cycles left of the unstretched enable
    logic [STROBE_N-1:0] strobe_reg; // Active-high select, one bit per strobe
    logic useReady_reg; // Cycle must wait for extReady
    logic [19:0] cycleAddr_reg; // Address of the cycle in progress

    // Decoder results
    logic [STROBE_N-1:0] decSel;
    logic [3:0] decWait;
    logic decUseReady;
    logic waitZero;
    logic startTaken; // Cycle start accepted this edge
    logic regAccess; // Start addresses a control register
    logic [15:0] ioAddr;

    assign ioAddr = addr[15:0];
    assign startTaken = cycleStart && state_reg == ST_IDLE;
    assign regAccess = ioCycle && (ioAddr == OFS_UPPER_CTL || ioAddr == OFS_LOWER_CTL
        || ioAddr == OFS_PER_BASE || ioAddr == OFS_MID_CTL || ioAddr == OFS_PER_OPT);

    region_decoder u_decoder (
        .addr(addr),
        .ioCycle(ioCycle),
        .upperCtl(upperCtl_reg),
        .lowerCtl(lowerCtl_reg),
        .perBase(perBase_reg),
        .midCtl(midCtl_reg),
        .perOpt(perOpt_reg),
        .sel(decSel),
        .waitCount(decWait),
        .useReady(decUseReady)
    );

    // Wait counter loads at every accepted start
    wait_counter u_wait (
        .clk(clk),
        .rst_n(rst_n),
        .load(startTaken),
        .loadValue(decWait),
        .step(state_reg == ST_WAIT || (state_reg == ST_BASE && baseCnt_reg == 2'b00)),
        .isZero(waitZero)
    );

    // Register writes; reset to the start-up mapping so booting works
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upperCtl_reg <= RST_UPPER_CTL;
            lowerCtl_reg <= RST_LOWER_CTL;
            perBase_reg <= RST_PER_BASE;
            midCtl_reg <= RST_MID_CTL;
            perOpt_reg <= RST_PER_OPT;
        end else if (startTaken && writeCycle && regAccess) begin
            case (ioAddr)
                OFS_UPPER_CTL: upperCtl_reg <= writeData;
                OFS_LOWER_CTL: lowerCtl_reg <= writeData;
                OFS_PER_BASE: perBase_reg <= writeData;
                OFS_MID_CTL: midCtl_reg <= writeData;
                OFS_PER_OPT: perOpt_reg <= writeData;
                default: upperCtl_reg <= upperCtl_reg;
            endcase
        end
    end

    // Register reads; other I/O reads answer zero here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readData_reg <= READ_NONE;
            regHit_reg <= 1'b0;
        end else if (startTaken && !writeCycle) begin
            regHit_reg <= regAccess;
            case (regAccess ? ioAddr : 16'h0000)
                OFS_UPPER_CTL: readData_reg <= upperCtl_reg;
                OFS_LOWER_CTL: readData_reg <= lowerCtl_reg;
                OFS_PER_BASE: readData_reg <= perBase_reg;
                OFS_MID_CTL: readData_reg <= midCtl_reg;
                OFS_PER_OPT: readData_reg <= perOpt_reg;
                default: readData_reg <= READ_NONE;
            endcase
        end else if (startTaken) begin
            regHit_reg <= regAccess;
        end
    end

    // Next state: base enable time, then wait states, then optional ready
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (startTaken) begin
                    state_next = ST_BASE;
                end
            end
            ST_BASE: begin
                if (baseCnt_reg == 2'b00) begin
                    if (!waitZero) begin
                        state_next = ST_WAIT;
                    end else if (useReady_reg && !extReady) begin
                        state_next = ST_READY;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                // The count already stepped in the last base cycle, so zero ends here
                if (waitZero) begin
                    state_next = (useReady_reg && !extReady) ? ST_READY : ST_IDLE;
                end
            end
            ST_READY: begin
                if (extReady) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Base enable counter, reloaded at each start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baseCnt_reg <= 2'b00;
        end else if (startTaken) begin
            baseCnt_reg <= BASE_LAST;
        end else if (state_reg == ST_BASE && baseCnt_reg != 2'b00) begin
            baseCnt_reg <= baseCnt_reg - 2'b01;
        end
    end

    // Strobe latch: held from start until the cycle ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_reg <= '0;
            useReady_reg <= 1'b0;
            cycleAddr_reg <= 20'h0_0000;
        end else if (startTaken) begin
            // Register accesses are internal and drive no strobe
            strobe_reg <= regAccess ? '0 : decSel;
            useReady_reg <= decUseReady;
            cycleAddr_reg <= addr;
        end else if (state_next == ST_IDLE) begin
            strobe_reg <= '0;
        end
    end

    // Pins and handshake
    assign cycleBusy = (state_reg != ST_IDLE);
    assign cycleDone = cycleBusy && state_next == ST_IDLE;
    assign readData = readData_reg;
    assign regHit = regHit_reg;
    assign upperStrobe_n = !strobe_reg[SEL_UPPER];
    assign lowerStrobe_n = !strobe_reg[SEL_LOWER];
    assign firstMidStrobe_n = !strobe_reg[SEL_MID];
    assign lowPeriphStrobes_n = ~strobe_reg[SEL_LOW_PER+:LOW_PER_N];
    assign highPeriphStrobes_n = ~strobe_reg[SEL_HIGH_PER+:HIGH_PER_N];

    // Checks on the strobes and their timing
    property p_upper_range;
        @(posedge clk) disable iff (!rst_n)
        !upperStrobe_n |-> cycleAddr_reg[19:16] >= upperCtl_reg[REGION_MSB:REGION_LSB];
    endproperty
    a_upper_range: assert property (p_upper_range) else $error("upper strobe out of range");

    property p_upper_hit;
        @(posedge clk) disable iff (!rst_n)
        startTaken && !ioCycle && upperCtl_reg == RST_UPPER_CTL && addr[19]
            && !decSel[SEL_MID] |=> !upperStrobe_n;
    endproperty
    a_upper_hit: assert property (p_upper_hit) else $error("upper half not mapped");

    property p_upper_waits;
        @(posedge clk) disable iff (!rst_n)
        startTaken && decSel[SEL_UPPER] && !regAccess && upperCtl_reg == RST_UPPER_CTL
            |=> (!upperStrobe_n) [*5] ##1 upperStrobe_n;
    endproperty
    a_upper_waits: assert property (p_upper_waits) else $error("upper enable not 5 cycles");

    property p_lower_range;
        @(posedge clk) disable iff (!rst_n)
        !lowerStrobe_n |-> cycleAddr_reg[19:16] <= lowerCtl_reg[REGION_MSB:REGION_LSB];
    endproperty
    a_lower_range: assert property (p_lower_range) else $error("lower strobe out of range");

    property p_lower_default;
        @(posedge clk) disable iff (!rst_n)
        startTaken && decSel[SEL_LOWER] && !regAccess && lowerCtl_reg == RST_LOWER_CTL
            |-> ##5 cycleDone;
    endproperty
    a_lower_default: assert property (p_lower_default) else $error("lower cycle length");

    property p_mid_range;
        @(posedge clk) disable iff (!rst_n)
        !firstMidStrobe_n |-> cycleAddr_reg[19:16] >= midCtl_reg[REGION_MSB:REGION_LSB];
    endproperty
    a_mid_range: assert property (p_mid_range) else $error("mid strobe below window");

    property p_low_per_slow;
        @(posedge clk) disable iff (!rst_n)
        startTaken && (|decSel[SEL_LOW_PER+:LOW_PER_N]) && !regAccess
            && perBase_reg[CODE3_MSB:WAIT2_LSB] == CODE_SLOWEST
            && perBase_reg[PER_NORDY_BIT] |-> ##17 cycleDone;
    endproperty
    a_low_per_slow: assert property (p_low_per_slow) else $error("slow code not 15 waits");

    property p_per_block;
        @(posedge clk) disable iff (!rst_n)
        !lowPeriphStrobes_n[1] |-> cycleAddr_reg[15:8]
            == {perBase_reg[PER_BASE_MSB:PER_BASE_LSB], 2'b01};
    endproperty
    a_per_block: assert property (p_per_block) else $error("peripheral block misplaced");

    property p_one_strobe;
        @(posedge clk) disable iff (!rst_n)
        $onehot0(strobe_reg) && (cycleBusy || strobe_reg == '0);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("strobes overlap or linger");

    property p_done_at_zero;
        @(posedge clk) disable iff (!rst_n)
        cycleDone |-> waitZero && state_reg != ST_IDLE;
    endproperty
    a_done_at_zero: assert property (p_done_at_zero) else $error("cycle ended early");

    // A cycle with no waits and no ready lasts exactly the base enable time
    property p_base_only;
        @(posedge clk) disable iff (!rst_n)
        startTaken && decWait == WAIT_ZERO && !decUseReady |-> ##2 cycleDone;
    endproperty
    a_base_only: assert property (p_base_only) else $error("zero-wait cycle length");

    // A cycle that waits for ready may only end while ready is high
    property p_ready_end;
        @(posedge clk) disable iff (!rst_n)
        cycleDone && useReady_reg |-> extReady;
    endproperty
    a_ready_end: assert property (p_ready_end) else $error("ended without ready");

    // Strobes must not change while a cycle runs, wait states included
    property p_strobe_hold;
        @(posedge clk) disable iff (!rst_n)
        cycleBusy && !cycleDone |=> strobe_reg == $past(strobe_reg);
    endproperty
    a_strobe_hold: assert property (p_strobe_hold) else $error("strobe changed mid-cycle");
endmodule

// File: tb/far_side_chips.sv
// Behavioural model of the ROM, RAM and peripheral chips beyond the strobes.
// Assumes the strobes come straight from the unit; only the ready line answers.
`timescale 1ns/1ns
module far_side_chips
    import cs_wait_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [STROBE_N-1:0] strobes_n,
    input wire logic [3:0] slowLag,
    output logic extReady
);
    logic [3:0] lagCnt; // Cycles since some strobe fell
    logic idlePat; // Free pattern for a line that nobody answers on
    logic anyLow; // Some chip is selected

    assign anyLow = ~&strobes_n;

    // A slow part raises ready only after slowLag selected cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lagCnt <= 4'h0;
            idlePat <= 1'b0;
        end else begin
            idlePat <= ~idlePat;
            if (!anyLow) begin
                lagCnt <= 4'h0;
            end else if (lagCnt != 4'hf) begin
                lagCnt <= lagCnt + 4'h1;
            end
        end
    end

    // Unselected, the line changes every cycle, so ignoring it is really tested
    assign extReady = anyLow ? (lagCnt >= slowLag) : idlePat;
endmodule

// File: tb/chip_select_wait_state_unit_bench.sv
// Self-checking bench for the chip-select and wait-state unit.
// Assumes the unit's package; the far-side model supplies the ready line.
`timescale 1ns/1ns
module chip_select_wait_state_unit_bench
    import cs_wait_pkg::*;
;
    typedef struct {
        logic [STROBE_N-1:0] sel;
        int len;
        bit chk;
        logic [15:0] data;
        bit hit;
    } note_t;

    logic clk, rst_n, cycleStart, ioCycle, writeCycle, extReady, regHit, cycleBusy, cycleDone;
    logic [19:0] addr;
    logic [15:0] writeData, readData;
    logic upperStrobe_n, lowerStrobe_n, firstMidStrobe_n;
    logic [LOW_PER_N-1:0] lowPeriphStrobes_n;
    logic [HIGH_PER_N-1:0] highPeriphStrobes_n;
    logic [STROBE_N-1:0] strobes; // All strobes, bit index as the SEL_ constants
    logic [3:0] slowLag; // Zero: the far side answers at once
    logic pokeNext; // Fire an extra start in mid-cycle
    note_t notes[$]; // Expected results, oldest first
    int n_fail, cmp_count, len, cycles;
    logic [3:0] waitTab[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hf};

    assign strobes = {highPeriphStrobes_n, lowPeriphStrobes_n, firstMidStrobe_n,
                      lowerStrobe_n, upperStrobe_n};

    chip_select_wait_state_unit i_dut (.clk(clk), .rst_n(rst_n), .cycleStart(cycleStart),
        .addr(addr), .ioCycle(ioCycle), .writeCycle(writeCycle), .writeData(writeData),
        .extReady(extReady), .readData(readData), .regHit(regHit), .cycleBusy(cycleBusy),
        .cycleDone(cycleDone), .upperStrobe_n(upperStrobe_n), .lowerStrobe_n(lowerStrobe_n),
        .firstMidStrobe_n(firstMidStrobe_n), .lowPeriphStrobes_n(lowPeriphStrobes_n),
        .highPeriphStrobes_n(highPeriphStrobes_n));

    far_side_chips i_far (.clk(clk), .rst_n(rst_n), .strobes_n(strobes), .slowLag(slowLag),
        .extReady(extReady));

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic tally(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkSel(input logic [STROBE_N-1:0] exp);
        tally("strobes", 16'(exp), 16'(strobes));
    endtask
    task automatic checkLen(input int exp);
        tally("cycle length", 16'(exp), 16'(len));
    endtask
    task automatic checkData(input logic [15:0] exp);
        tally("read data", exp, readData);
    endtask
    task automatic checkHit(input logic exp);
        tally("register hit", 16'(exp), 16'(regHit));
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            conclude();
        end
    end

    // Watcher: strobes held through each cycle, length and answer at its end
    always @(negedge clk) begin
        if (rst_n === 1'b1) begin
            if (cycleBusy === 1'b1 && notes.size() > 0) begin
                len++;
                checkSel(notes[0].sel);
                if (cycleDone === 1'b1) begin
                    checkLen(notes[0].len);
                    checkHit(notes[0].hit);
                    if (notes[0].chk) begin
                        checkData(notes[0].data);
                    end
                    void'(notes.pop_front());
                    len = 0;
                end
            end else if (cycleBusy !== 1'b1) begin
                checkSel('1);
            end
        end
    end

    // One whole bus cycle; the next may start once this returns
    task automatic runCycle(input logic io, input logic wr, input logic [19:0] a,
                            input logic [15:0] d, input logic [STROBE_N-1:0] sel,
                            input int n, input bit chk);
        int i;
        bit hit;
        // Only the five control register offsets in I/O space count as a register hit
        hit = io && (a[15:0] inside {OFS_UPPER_CTL, OFS_LOWER_CTL, OFS_PER_BASE, OFS_MID_CTL,
                                     OFS_PER_OPT});
        notes.push_back('{sel, n, chk, d, hit});
        @(posedge clk);
        cycleStart <= 1'b1;
        ioCycle <= io;
        writeCycle <= wr;
        addr <= a;
        writeData <= wr ? d : 16'($urandom());
        @(posedge clk);
        cycleStart <= 1'b0;
        if (pokeNext) begin
            repeat (3) @(posedge clk);
            cycleStart <= 1'b1;
            ioCycle <= 1'b0;
            addr <= 20'h8_0000;
            @(posedge clk);
            cycleStart <= 1'b0;
        end
        for (i = 0; i < 40 && cycleDone !== 1'b1; i++) begin
            @(negedge clk);
        end
    endtask

    function automatic logic [STROBE_N-1:0] one(input int idx);
        return ~(STROBE_N'(1) << idx);
    endfunction
    function automatic int span(input logic [3:0] w);
        return BASE_CYCLES + int'(w) * STEP_CYCLES;
    endfunction
    task automatic regRd(input logic [15:0] ofs, input logic [15:0] exp);
        runCycle(1'b1, 1'b0, {4'h0, ofs}, exp, '1, BASE_CYCLES, 1'b1);
    endtask
    task automatic regWr(input logic [15:0] ofs, input logic [15:0] v);
        runCycle(1'b1, 1'b1, {4'h0, ofs}, v, '1, BASE_CYCLES, 1'b0);
    endtask
    task automatic mem(input logic [19:0] a, input int idx, input logic [3:0] w);
        runCycle(1'b0, 1'b0, a, 16'h0000, one(idx), span(w), 1'b0);
    endtask
    task automatic io(input logic [19:0] a, input int idx, input logic [3:0] w);
        runCycle(1'b1, 1'b0, a, 16'h0000, one(idx), span(w), 1'b0);
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        cycleStart = 1'b0;
        ioCycle = 1'b0;
        writeCycle = 1'b0;
        addr = 20'h0_0000;
        writeData = 16'h0000;
        slowLag = 4'h0;
        pokeNext = 1'b0;
        void'($urandom(32'h38e0));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        regRd(OFS_UPPER_CTL, RST_UPPER_CTL);
        regRd(OFS_LOWER_CTL, RST_LOWER_CTL);
        regRd(OFS_PER_BASE, RST_PER_BASE);
        regRd(OFS_MID_CTL, RST_MID_CTL);
        regRd(OFS_PER_OPT, RST_PER_OPT);
        regRd(16'hffaa, READ_NONE);
        mem(20'hc_0000 | 20'($urandom() & 32'h3_ffff), SEL_UPPER, 4'h3);
        mem(20'hf_ffff, SEL_UPPER, 4'h3);
        mem(20'h8_0000 | 20'($urandom() & 32'h3_ffff), SEL_MID, 4'h3);
        mem(20'hb_ffff, SEL_MID, 4'h3);
        mem(20'h0_0000, SEL_LOWER, 4'h3);
        mem(20'($urandom() & 32'h7_ffff), SEL_LOWER, 4'h3);
        mem(20'h7_ffff, SEL_LOWER, 4'h3);
        for (int k = 0; k < LOW_PER_N; k++) begin
            pokeNext = (k == 1);
            io(20'(k * 32'h100 + ($urandom() & 32'hff)), SEL_LOW_PER + k, 4'hf);
        end
        pokeNext = 1'b0;
        for (int k = 0; k < HIGH_PER_N; k++) begin
            io(20'((HIGH_PER_FIRST + k) * 32'h100 + ($urandom() & 32'hff)),
               SEL_HIGH_PER + k, 4'h3);
        end
        for (int c = 0; c < 8; c++) begin
            regWr(OFS_PER_BASE, 16'h0078 | 16'(c));
            regRd(OFS_PER_BASE, 16'h0078 | 16'(c));
            io(20'h0_0200 | 20'($urandom() & 32'hff), SEL_LOW_PER + 2, waitTab[c]);
        end
        regWr(OFS_UPPER_CTL, 16'h80bc);
        mem(20'hd_0000, SEL_UPPER, 4'h0);
        regWr(OFS_LOWER_CTL, 16'h7fbb);
        mem(20'h0_1234, SEL_LOWER, 4'h3);
        // Slow part: ready rises after slowLag selected cycles, past the three waits
        @(posedge clk);
        slowLag <= 4'(5 + $urandom() % 8);
        @(negedge clk);
        runCycle(1'b0, 1'b0, 20'h0_4321, 16'h0000, one(SEL_LOWER),
                 int'(slowLag) + 1, 1'b0);
        slowLag <= 4'h0;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        regRd(OFS_UPPER_CTL, RST_UPPER_CTL);
        mem(20'he_0000, SEL_UPPER, 4'h3);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
